// file: temp_limit_status_alert_tb_top.sv
// Self-checking bench of the limit, status and alert block.
// Assumes short slot counts so that a full round robin takes about twenty cycles.
`timescale 1ns/100ps
`include "tlsa_map.svh"

`define CHK(act, exp) begin n_compared++; if ((act) !== (exp)) begin n_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, act, exp); end end

module temp_limit_status_alert_tb_top;
    logic       clk, rst_b, wr, rd, ara, dfault, ontime, pin, f1, fa, f2;
    logic [7:0] addr, wdata, adc, hi, lo, ot, rdata, vdata;
    logic [1:0] chan, vchan;
    logic       busy, vwe, otout, aout, aoe;
    int         n_errors, n_compared;
    localparam int LOC_CYC = 4;
    localparam int REM_CYC = 8;

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    tlsa_host_model i_tlsa_host_model (.i_sys_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr),
        .o_rd(rd), .o_wdata(wdata));

    tlsa_core #(.W(8), .LOCAL_SLOT_CYC(LOC_CYC), .REMOTE_SLOT_CYC(REM_CYC)) i_tlsa_core (
        .i_sys_clk(clk), .i_rst_b(rst_b), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_wdata(wdata), .i_ara_done(ara), .i_adc_value(adc), .i_diode_fault(dfault),
        .i_high_lim0(hi), .i_high_lim1(hi), .i_high_lim2(hi), .i_low_lim0(lo), .i_low_lim1(lo),
        .i_low_lim2(lo), .i_ot_lim0(ot), .i_ot_lim1(ot), .i_ot_lim2(ot), .i_ontime_exc(ontime),
        .i_overtemp_pin(pin), .i_fan_one_stall(f1), .i_fans_alarm(fa), .i_fan_two_stall(f2),
        .o_reg_rdata(rdata), .o_channel(chan), .o_conv_busy(busy), .o_value_we(vwe),
        .o_value_chan(vchan), .o_value_data(vdata), .o_overtemp_out(otout), .o_alert_out(aout),
        .o_alert_oe(aoe));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic wrap_up();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_tlsa_host_model.rd(a, d);
        `CHK(d, e)
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    // The first strobe after a stimulus change may carry a stale sample, so four are awaited.
    task automatic round();
        int         n;
        int         gap;
        logic [1:0] last;
        n = 0;
        gap = 0;
        last = 2'h3;
        for (int k = 0; k < 400 && n < 4; k++) begin
            @(posedge clk);
            #1;
            gap++;
            if (vwe === 1'b1) begin
                if (n > 0) begin
                    `CHK(vchan, (last == 2'h2) ? 2'h0 : last + 2'h1)
                    `CHK(vdata, adc)
                    `CHK(gap, (vchan == 2'h0) ? LOC_CYC : REM_CYC)
                end
                last = vchan;
                gap = 0;
                n++;
            end
        end
        if (n < 4) begin
            n_errors++;
            wrap_up();
        end
        settle();
    endtask

    task automatic set_adc(input logic [7:0] v);
        @(posedge clk);
        adc <= v;
        round();
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        logic [7:0] d;
        int         cnt;
        {rst_b, ara, dfault, ontime, pin, f1, fa, f2} = 8'h00;
        adc = 8'h60;
        hi = 8'h80;
        lo = 8'h40;
        ot = 8'hf0;
        n_errors = 0;
        n_compared = 0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rdc(`TLSA_OFS_CFG1, `TLSA_CFG1_RESET);
        rdc(`TLSA_OFS_MASK3, 8'h00);
        rdc(8'h20, 8'h00);
        round();
        rdc(`TLSA_OFS_FLAGS1, 8'h00);
        set_adc(8'h80);
        `CHK(aoe, 1'b1)
        `CHK(aout, 1'b0)
        rdc(`TLSA_OFS_FLAGS3, 8'h01);
        rdc(`TLSA_OFS_FLAGS1, 8'ha4);
        rdc(`TLSA_OFS_FLAGS1, 8'ha4);
        set_adc(8'h7f);
        `CHK(aoe, 1'b1)
        rdc(`TLSA_OFS_FLAGS1, 8'ha4);
        rdc(`TLSA_OFS_FLAGS1, 8'h00);
        settle();
        `CHK(aoe, 1'b0)
        set_adc(8'h40);
        rdc(`TLSA_OFS_FLAGS1, 8'h00);
        set_adc(8'h3f);
        rdc(`TLSA_OFS_FLAGS1, 8'h52);
        @(posedge clk);
        dfault <= 1'b1;
        set_adc(8'h60);
        rdc(`TLSA_OFS_FLAGS1, 8'h5b);
        rdc(`TLSA_OFS_FLAGS1, 8'h09);
        @(posedge clk);
        dfault <= 1'b0;
        round();
        @(posedge clk);
        ara <= 1'b1;
        @(posedge clk);
        ara <= 1'b0;
        rdc(`TLSA_OFS_FLAGS1, 8'h00);
        `CHK(aoe, 1'b0)
        i_tlsa_host_model.wr(`TLSA_OFS_MASK1, 8'hff);
        set_adc(8'h80);
        `CHK(aoe, 1'b0)
        rdc(`TLSA_OFS_FLAGS1, 8'ha4);
        i_tlsa_host_model.wr(`TLSA_OFS_MASK1, 8'h00);
        i_tlsa_host_model.wr(`TLSA_OFS_CFG1, 8'h09);
        settle();
        `CHK(aoe, 1'b1)
        set_adc(8'h60);
        `CHK(aoe, 1'b0)
        rdc(`TLSA_OFS_FLAGS1, 8'ha4);
        @(posedge clk);
        pin <= 1'b1;
        settle();
        `CHK(aoe, 1'b0)
        rdc(`TLSA_OFS_FLAGS2, 8'h04);
        rdc(`TLSA_OFS_FLAGS2, 8'h04);
        @(posedge clk);
        pin <= 1'b0;
        rdc(`TLSA_OFS_FLAGS2, 8'h04);
        rdc(`TLSA_OFS_FLAGS2, 8'h00);
        i_tlsa_host_model.wr(`TLSA_OFS_CFG1, 8'h01);
        @(posedge clk);
        {ontime, f1, fa, f2} <= 4'hf;
        set_adc(8'hf0);
        `CHK(otout, 1'b1)
        rdc(`TLSA_OFS_FLAGS2, 8'hf8);
        rdc(`TLSA_OFS_FLAGS3, 8'he1);
        @(posedge clk);
        {ontime, f1, fa, f2} <= 4'h0;
        set_adc(8'h60);
        i_tlsa_host_model.rd(`TLSA_OFS_FLAGS1, d);
        i_tlsa_host_model.rd(`TLSA_OFS_FLAGS2, d);
        i_tlsa_host_model.rd(`TLSA_OFS_FLAGS3, d);
        i_tlsa_host_model.wr(`TLSA_OFS_CFG1, 8'h00);
        settle();
        `CHK(busy, 1'b0)
        `CHK(chan, 2'h3)
        @(posedge clk);
        f2 <= 1'b1;
        cnt = 0;
        for (int k = 0; k < 40; k++) begin
            @(posedge clk);
            #1;
            if (vwe === 1'b1) cnt++;
        end
        `CHK(cnt, 0)
        rdc(`TLSA_OFS_FLAGS3, 8'h21);
        i_tlsa_host_model.wr(`TLSA_OFS_CFG1, 8'h01);
        round();
        wrap_up();
    end
endmodule

// file: tlsa_core.sv
// Limit comparison, sticky status registers and alert output of a temperature monitor.
// Assumes a register port with one-cycle read and write strobes, synchronous to i_sys_clk.
// How it works
// - high flag when value at or above limit
// - low flag only when value below limit
// - monitoring starts at reset, restarts on enable
// - clearing enable stops the round robin
// - each finished conversion stores its value register
// - local slot 11 ms, remote slots 32 ms
// - after the cycle, restart at first channel
// - fan inputs sampled independent of temperature sequence
// - status bit one means out of limit
// - sticky until condition gone, then read or response
// - first status register bit order fixed
// - diode fault flags open or shorted diode
// - second register overtemp, percent, asserted flags
// - pin state clears on read or response once idle; never comparator alert
// - third register fan stalls and alarm speed
// - third register bit zero shows alert driven
// - mask bits gate alert, status still sets
// - any unmasked out of limit drives alert low
// - latched mode holds alert until cleared
// - comparator mode releases alert when in limit
// - config bit three selects comparator mode
`timescale 1ns/100ps
`include "tlsa_map.svh"

module tlsa_core #(
    parameter int W                = 8,
    parameter int LOCAL_SLOT_CYC   = `TLSA_LOCAL_SLOT_MS * `TLSA_CLK_KHZ,
    parameter int REMOTE_SLOT_CYC  = `TLSA_REMOTE_SLOT_MS * `TLSA_CLK_KHZ
) (
    input  wire logic         i_sys_clk,       // System clock, 125 MHz.
    input  wire logic         i_rst_b,         // Synchronous reset, active low.
    input  wire logic [7:0]   i_reg_addr,      // Register address.
    input  wire logic         i_reg_wr,        // One-cycle write strobe.
    input  wire logic         i_reg_rd,        // One-cycle read strobe.
    input  wire logic [7:0]   i_reg_wdata,     // Write data.
    input  wire logic         i_ara_done,      // Pulse: alert-response transaction completed.
    input  wire logic [W-1:0] i_adc_value,     // Result of the current conversion.
    input  wire logic         i_diode_fault,   // Diode open or short on the current channel.
    input  wire logic [W-1:0] i_high_lim0,     // Local high limit.
    input  wire logic [W-1:0] i_high_lim1,     // Remote one high limit.
    input  wire logic [W-1:0] i_high_lim2,     // Remote two high limit.
    input  wire logic [W-1:0] i_low_lim0,      // Local low limit.
    input  wire logic [W-1:0] i_low_lim1,      // Remote one low limit.
    input  wire logic [W-1:0] i_low_lim2,      // Remote two low limit.
    input  wire logic [W-1:0] i_ot_lim0,       // Local overtemperature limit.
    input  wire logic [W-1:0] i_ot_lim1,       // Remote one overtemperature limit.
    input  wire logic [W-1:0] i_ot_lim2,       // Remote two overtemperature limit.
    input  wire logic         i_ontime_exc,    // Overtemp pin on-time percentage exceeded.
    input  wire logic         i_overtemp_pin,  // Overtemperature pin active level.
    input  wire logic         i_fan_one_stall, // Fan one stalled.
    input  wire logic         i_fans_alarm,    // Both fans at alarm speed.
    input  wire logic         i_fan_two_stall, // Fan two stalled.
    output logic [7:0]        o_reg_rdata,     // Read data, valid the cycle after i_reg_rd.
    output logic [1:0]        o_channel,       // Channel being converted.
    output logic              o_conv_busy,     // Round robin running.
    output logic              o_value_we,      // Pulse: store o_value_data for o_value_chan.
    output logic [1:0]        o_value_chan,    // Channel of the stored value.
    output logic [W-1:0]      o_value_data,    // Value to store.
    output logic              o_overtemp_out,  // Overtemp output asserted by a limit.
    output logic              o_alert_out,     // Open-drain alert output level, always 0.
    output logic              o_alert_oe       // High while the alert line is pulled low.
);

    // ****************************************
    // Configuration and masks
    // ****************************************
    logic [7:0]  cfg1;
    logic [7:0]  mask1;
    logic [7:0]  mask2;
    logic [7:0]  mask3;
    logic        mon_en;
    logic        cmp_mode;

    assign mon_en   = cfg1[`TLSA_CFG1_MON_BIT];
    assign cmp_mode = cfg1[`TLSA_CFG1_CMP_BIT];

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            cfg1  <= `TLSA_CFG1_RESET;
            mask1 <= `TLSA_MASK_RESET;
            mask2 <= `TLSA_MASK_RESET;
            mask3 <= `TLSA_MASK_RESET;
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                `TLSA_OFS_CFG1:  cfg1  <= i_reg_wdata;
                `TLSA_OFS_MASK1: mask1 <= i_reg_wdata;
                `TLSA_OFS_MASK2: mask2 <= i_reg_wdata;
                `TLSA_OFS_MASK3: mask3 <= i_reg_wdata;
                default: ;
            endcase
        end
    end

    // ****************************************
    // Round-robin sequencer
    // ****************************************
    tlsa_pkg::tlsa_chan_e chan;
    logic [31:0]          slot_cnt;
    logic [31:0]          slot_len;
    logic                 slot_end;

    assign slot_len = (chan == tlsa_pkg::TLSA_CH_LOCAL) ? 32'(LOCAL_SLOT_CYC) : 32'(REMOTE_SLOT_CYC);
    assign slot_end = mon_en && (chan != tlsa_pkg::TLSA_CH_IDLE) && (slot_cnt == slot_len - 32'h1);

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            chan     <= tlsa_pkg::TLSA_CH_LOCAL;
            slot_cnt <= 32'h0;
        end else if (!mon_en) begin
            chan     <= tlsa_pkg::TLSA_CH_IDLE;
            slot_cnt <= 32'h0;
        end else begin
            case (chan)
                tlsa_pkg::TLSA_CH_IDLE: begin
                    chan <= tlsa_pkg::TLSA_CH_LOCAL;
                end
                default: begin
                    if (slot_end) begin
                        slot_cnt <= 32'h0;
                        case (chan)
                            tlsa_pkg::TLSA_CH_LOCAL:      chan <= tlsa_pkg::TLSA_CH_REMOTE_ONE;
                            tlsa_pkg::TLSA_CH_REMOTE_ONE: chan <= tlsa_pkg::TLSA_CH_REMOTE_TWO;
                            default:                      chan <= tlsa_pkg::TLSA_CH_LOCAL;
                        endcase
                    end else begin
                        slot_cnt <= slot_cnt + 32'h1;
                    end
                end
            endcase
        end
    end

    // Value register write strobe, issued as each slot ends.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_value_we   <= 1'b0;
            o_value_chan <= 2'h0;
            o_value_data <= '0;
            o_channel    <= 2'h0;
            o_conv_busy  <= 1'b0;
        end else begin
            o_value_we   <= slot_end;
            o_value_chan <= chan;
            o_value_data <= i_adc_value;
            o_channel    <= chan;
            o_conv_busy  <= mon_en;
        end
    end

    // ****************************************
    // Limit comparison
    // ****************************************
    logic [W-1:0] hi_lim;
    logic [W-1:0] lo_lim;
    logic [W-1:0] ot_lim;
    logic [2:0]   hi_hit;
    logic [2:0]   lo_hit;
    logic [2:0]   ot_hit;
    logic [2:0]   df_hit;
    logic [2:0]   ot_cond;

    always_comb begin
        case (chan)
            tlsa_pkg::TLSA_CH_REMOTE_ONE: begin hi_lim = i_high_lim1; lo_lim = i_low_lim1; ot_lim = i_ot_lim1; end
            tlsa_pkg::TLSA_CH_REMOTE_TWO: begin hi_lim = i_high_lim2; lo_lim = i_low_lim2; ot_lim = i_ot_lim2; end
            default:                      begin hi_lim = i_high_lim0; lo_lim = i_low_lim0; ot_lim = i_ot_lim0; end
        endcase
    end

    // Conditions latch per channel at each slot end so that they persist until re-measured.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            hi_hit <= 3'h0;
            lo_hit <= 3'h0;
            ot_hit <= 3'h0;
            df_hit <= 3'h0;
        end else if (slot_end) begin
            hi_hit[chan] <= (i_adc_value >= hi_lim);
            lo_hit[chan] <= (i_adc_value < lo_lim);
            ot_hit[chan] <= (i_adc_value >= ot_lim);
            df_hit[chan] <= i_diode_fault && (chan != tlsa_pkg::TLSA_CH_LOCAL);
        end
    end
    assign ot_cond = ot_hit;

    // ****************************************
    // Sticky status registers
    // ****************************************
    logic [7:0] cond1;
    logic [7:0] cond2;
    logic [7:0] cond3;
    logic [7:0] flags1;
    logic [7:0] flags2;
    logic [7:0] flags3;
    logic       rd1;
    logic       rd2;
    logic       rd3;

    // Fan inputs are sampled every cycle, never tied to the temperature slots.
    assign cond1 = {hi_hit[0], lo_hit[0], hi_hit[1], lo_hit[1], df_hit[1], hi_hit[2], lo_hit[2], df_hit[2]};
    assign cond2 = {ot_cond[0], ot_cond[1], ot_cond[2], i_ontime_exc, o_overtemp_out, i_overtemp_pin, 2'h0};
    assign cond3 = {i_fan_one_stall, i_fans_alarm, i_fan_two_stall, 5'h00};

    assign rd1 = (i_reg_rd && i_reg_addr == `TLSA_OFS_FLAGS1) || i_ara_done;
    assign rd2 = (i_reg_rd && i_reg_addr == `TLSA_OFS_FLAGS2) || i_ara_done;
    assign rd3 = (i_reg_rd && i_reg_addr == `TLSA_OFS_FLAGS3) || i_ara_done;

    // A bit clears only where its condition has gone; a present condition always sets.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            flags1 <= `TLSA_FLAGS_RESET;
            flags2 <= `TLSA_FLAGS_RESET;
            flags3 <= `TLSA_FLAGS_RESET;
        end else begin
            flags1 <= cond1 | (rd1 ? 8'h00 : flags1);
            flags2 <= (cond2 | (rd2 ? 8'h00 : flags2)) & `TLSA_FLAGS2_USED;
            flags3 <= (cond3 | (rd3 ? 8'h00 : flags3)) & `TLSA_FLAGS3_USED;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_overtemp_out <= 1'b0;
        end else begin
            o_overtemp_out <= |ot_cond;
        end
    end

    // ****************************************
    // Alert output and read data
    // ****************************************
    logic [7:0] src2_cmp;
    logic       alert_src;
    logic       alert_cond;
    logic       next_alert;

    // The pin-state bit never raises the alert in comparator mode.
    assign src2_cmp   = cmp_mode ? (8'hff ^ (8'h01 << `TLSA_PIN_BIT)) : 8'hff;
    assign alert_src  = |(flags1 & ~mask1) | |(flags2 & ~mask2 & src2_cmp) | |(flags3 & ~mask3);
    assign alert_cond = |(cond1 & ~mask1) | |(cond2 & ~mask2 & src2_cmp) | |(cond3 & ~mask3);
    assign next_alert = cmp_mode ? alert_cond : alert_src;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_alert_oe <= 1'b0;
        end else begin
            o_alert_oe <= next_alert;
        end
    end
    // The line is open drain, so only its enable ever moves.
    always_ff @(posedge i_sys_clk) begin
        o_alert_out <= 1'b0;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                `TLSA_OFS_FLAGS1: o_reg_rdata <= flags1;
                `TLSA_OFS_FLAGS2: o_reg_rdata <= flags2;
                `TLSA_OFS_FLAGS3: o_reg_rdata <= flags3 | {7'h00, o_alert_oe};
                `TLSA_OFS_CFG1:   o_reg_rdata <= cfg1;
                `TLSA_OFS_MASK1:  o_reg_rdata <= mask1;
                `TLSA_OFS_MASK2:  o_reg_rdata <= mask2;
                `TLSA_OFS_MASK3:  o_reg_rdata <= mask3;
                default:          o_reg_rdata <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    chk_stuck_cond: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        ##1 ($past(cond1) & ~flags1) == 8'h00) else $error("Present condition not flagged.");
    chk_event_wins: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        rd1 && cond1[7] |=> flags1[7]) else $error("Event lost on clearing read.");
    chk_sticky_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        flags1[6] && !rd1 |=> flags1[6]) else $error("Status bit dropped without read.");
    chk_mask_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !cmp_mode && (flags1 & ~mask1) == 8'h00 && (flags2 & ~mask2) == 8'h00 && (flags3 & ~mask3) == 8'h00
        |=> !o_alert_oe)
        else $error("Alert with no status.");
    chk_cmp_release: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        cmp_mode && !alert_cond |=> !o_alert_oe) else $error("Comparator alert not released.");
    chk_latched_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !cmp_mode && o_alert_oe && !$past(rd1) && !$past(rd2) && !$past(rd3) && $stable(mask1) && $stable(mask2)
        && $stable(mask3) && $stable(cfg1) |=> o_alert_oe) else $error("Latched alert released early.");
    chk_standby: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !mon_en |=> !o_value_we && chan == tlsa_pkg::TLSA_CH_IDLE) else $error("Round robin did not stop.");
    chk_value_store: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        slot_end |=> o_value_we && o_value_chan == $past(chan)) else $error("Value not stored.");
    chk_wrap: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        slot_end && chan == tlsa_pkg::TLSA_CH_REMOTE_TWO |=> chan == tlsa_pkg::TLSA_CH_LOCAL)
        else $error("Round robin did not restart.");

    cov_latched: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) !cmp_mode && $rose(o_alert_oe));
    cov_cmp: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) cmp_mode && $fell(o_alert_oe));
    cov_race: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) rd1 && |cond1);
    cov_ara: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) i_ara_done && o_alert_oe);

endmodule

// file: tlsa_host_model.sv
// Host-side model of the register port of the limit, status and alert block.
// Assumes strobes are taken at a rising edge and read data lands at that same edge.
`timescale 1ns/100ps

module tlsa_host_model (
    input  wire logic       i_sys_clk, // System clock.
    input  wire logic [7:0] i_rdata,   // Read data from the block.
    output logic [7:0]      o_addr,    // Register address.
    output logic            o_wr,      // Write strobe.
    output logic            o_rd,      // Read strobe.
    output logic [7:0]      o_wdata    // Write data.
);
    initial begin
        o_addr = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = 8'h00;
    end

    // Address and data are inverted once released, so a design that samples them late sees garbage.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_sys_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_sys_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_sys_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1;
        d = i_rdata;
    endtask
endmodule

// file: tlsa_map.svh
// Register offsets, bit positions and timing figures of the limit, status and alert block.
// Assumes inclusion by bare name from the block's design file.
`ifndef TLSA_MAP_SVH
`define TLSA_MAP_SVH

`define TLSA_OFS_FLAGS1      8'h4f
`define TLSA_OFS_FLAGS2      8'h50
`define TLSA_OFS_FLAGS3      8'h51
`define TLSA_OFS_CFG1        8'h01
`define TLSA_OFS_MASK1       8'h08
`define TLSA_OFS_MASK2       8'h09
`define TLSA_OFS_MASK3       8'h0a
`define TLSA_CFG1_MON_BIT    0
`define TLSA_CFG1_CMP_BIT    3
`define TLSA_CFG1_RESET      8'h01
`define TLSA_MASK_RESET      8'h00
`define TLSA_FLAGS_RESET     8'h00
`define TLSA_FLAGS2_USED     8'hfc
`define TLSA_FLAGS3_USED     8'he0
`define TLSA_PIN_BIT         2
`define TLSA_ALERT_BIT       0
`define TLSA_LOCAL_SLOT_MS   11
`define TLSA_REMOTE_SLOT_MS  32
`define TLSA_CLK_KHZ         125000

`endif

// file: tlsa_pkg.sv
// Types shared by the limit, status and alert block.
// Assumes nothing of its surroundings.
package tlsa_pkg;
    typedef enum logic [1:0] {
        TLSA_CH_LOCAL,
        TLSA_CH_REMOTE_ONE,
        TLSA_CH_REMOTE_TWO,
        TLSA_CH_IDLE
    } tlsa_chan_e;
endpackage
